// ===== src/periph_bus_master.sv
// legacy peripheral bus master: commands, selects, address, data, reset
`timescale 1ns/1ps
`include "xbus_params.svh"

// Behaviour
// - microcontroller select low for I/O to 62h or 66h; high in reset, suspend
// - memory read command lets a memory slave drive the data bus
// - memory write command lets a memory slave latch the data bus
// - each programmable select low on non-dma I/O cycles inside its programmed range
// - peripheral reset active at power-up and hard reset, freed on power good
// - software hard reset drives peripheral reset for at least 1 ms
// - peripheral reset high in reset, low after reset and in suspend
// - 19-bit byte address for memory; only bits 15 to 0 for I/O
// - this block always owns the bus, slave and dma cycles alike
// - dma I/O cycles drive the address bus to zero
// - address zero after reset; last address kept in suspend
// - 8-bit two-way data path, floated during reset
// - bus clock is clock divided by four; held low in reset and in suspend
// - count-done asserted after the new address on the exhausting transfer
// - count-done low when no dma is active and inactive in reset
// - fast request shortens a 16-bit memory cycle to two bus clocks
// - fast request shortens 8-bit memory or I/O cycles to three clocks
// - fast request ignored on 16-bit I/O cycles
// - fast request ignored while ready is low; wait states follow ready
// - I/O read and write commands driven high in reset
module periph_bus_master #(
   parameter int HARD_RESET_CYCLES = `HARD_RESET_CYC
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        suspend,
   input  wire logic        power_good_in,
   input  wire logic        hard_reset_req,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic        req_dma,
   input  wire logic        req_last,
   input  wire logic        req_io,
   input  wire logic        req_write,
   input  wire logic        req_wide,
   input  wire logic [18:0] req_addr,
   input  wire logic [7:0]  req_wdata,
   output logic             rsp_valid,
   output logic [7:0]       rsp_data,
   input  wire logic [15:0] range0_base,
   input  wire logic [15:0] range0_limit,
   input  wire logic [15:0] range1_base,
   input  wire logic [15:0] range1_limit,
   input  wire logic        fast_cycle_req_n,
   input  wire logic        io_ready,
   output logic             periph_bus_clock,
   output logic [18:0]      periph_addr,
   input  wire logic [7:0]  periph_data_in,
   output logic [7:0]       periph_data_out,
   output logic             periph_data_oe_n,
   output logic             mem_read_cmd_n,
   output logic             mem_write_cmd_n,
   output logic             io_read_cmd_n,
   output logic             io_write_cmd_n,
   output logic             microcontroller_select_n,
   output logic             prog_select0_n,
   output logic             prog_select1_n,
   output logic             peripheral_reset_out,
   output logic             dma_count_done
);
   xbus_pkg::master_state_type r;
   xbus_pkg::master_state_type next_r;
   logic                       bus_tick;
   logic                       fifo_valid;
   logic                       fifo_pop;
   logic [`REQ_W-1:0]          fifo_word;
   logic [`REQ_W-1:0]          req_word;

   // i/o range test, shared by both programmable selects
   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // cycle length in bus clocks for a request word and the fast request
   function automatic logic [2:0] cycle_len(input logic [`REQ_W-1:0] w,
                                            input logic fast);
      logic wide;
      logic io;
      wide = w[`REQ_WIDE];
      io   = w[`REQ_IO];
      if (fast && wide && !io) begin
         cycle_len = `FAST_LEN_16BIT;
      end else if (fast && !wide) begin
         cycle_len = `FAST_LEN_8BIT;
      end else if (wide) begin
         cycle_len = `LEN_16BIT;
      end else begin
         cycle_len = `LEN_8BIT;
      end
   endfunction

   assign req_word = {req_dma, req_last, req_io, req_write, req_wide,
                      req_addr, req_wdata};

   periph_clock_div u_div (
      .clk       (clk),
      .resetn    (resetn),
      .suspend   (suspend),
      .bus_clock (periph_bus_clock),
      .bus_tick  (bus_tick)
   );

   // requests queue here so the user side can run ahead of the slow bus
   req_fifo #(
      .WIDTH (`REQ_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   (req_word),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_word)
   );

   // a new cycle starts only on a bus clock edge and never in suspend
   assign fifo_pop = fifo_valid && bus_tick && !suspend &&
                     (r.st == xbus_pkg::BUS_IDLE);

   always_comb begin
      logic        fast;
      logic        io16;
      logic [15:0] ioa;
      fast           = 1'b0;
      io16           = 1'b0;
      ioa            = 16'h0000;
      next_r         = r;
      next_r.rsp_valid = 1'b0;

      if (hard_reset_req) begin
         next_r.rst_cnt = `RST_CNT_W'(HARD_RESET_CYCLES);
      end else if (r.rst_cnt != '0) begin
         next_r.rst_cnt = r.rst_cnt - 1'b1;
      end
      next_r.peripheral_reset_out = !suspend &&
         (!power_good_in || hard_reset_req || (r.rst_cnt != '0));

      case (r.st)
         xbus_pkg::BUS_IDLE: begin
            if (fifo_pop) begin
               next_r.word    = fifo_word;
               next_r.elapsed = 3'h1;
               next_r.st      = xbus_pkg::BUS_ADDR;
               // address drive, dma i/o forced to zero
               if (fifo_word[`REQ_DMA] && fifo_word[`REQ_IO]) begin
                  next_r.periph_addr = `DMA_IO_ADDR;
               end else if (fifo_word[`REQ_IO]) begin
                  next_r.periph_addr = {3'h0,
                     fifo_word[`REQ_ADDR_LO+15:`REQ_ADDR_LO]};
               end else begin
                  next_r.periph_addr =
                     fifo_word[`REQ_ADDR_HI:`REQ_ADDR_LO];
               end
               // drive write data only on writes
               next_r.data_out  = fifo_word[`REQ_DATA_HI:0];
               next_r.data_oe_n = !fifo_word[`REQ_WRITE];
            end
         end
         xbus_pkg::BUS_ADDR: begin
            if (bus_tick) begin
               next_r.st      = xbus_pkg::BUS_CMD;
               next_r.elapsed = r.elapsed + 3'h1;
               ioa = r.periph_addr[15:0];
               next_r.mem_read_cmd_n  = r.word[`REQ_IO] ||
                                        r.word[`REQ_WRITE];
               next_r.mem_write_cmd_n = r.word[`REQ_IO] ||
                                        !r.word[`REQ_WRITE];
               next_r.io_read_cmd_n   = !r.word[`REQ_IO] ||
                                        r.word[`REQ_WRITE];
               next_r.io_write_cmd_n  = !r.word[`REQ_IO] ||
                                        !r.word[`REQ_WRITE];
               if (r.word[`REQ_IO] && !r.word[`REQ_DMA]) begin
                  next_r.microcontroller_select_n =
                     !((ioa == `MC_PORT_A) || (ioa == `MC_PORT_B));
                  next_r.prog_select0_n =
                     !in_range(ioa, range0_base, range0_limit);
                  next_r.prog_select1_n =
                     !in_range(ioa, range1_base, range1_limit);
               end
               // count-done once the address is out
               next_r.dma_count_done = r.word[`REQ_DMA] &&
                                       r.word[`REQ_LAST];
            end
         end
         xbus_pkg::BUS_CMD: begin
            if (bus_tick) begin
               io16 = r.word[`REQ_IO] && r.word[`REQ_WIDE];
               // fast request qualified by ready and width
               fast = !fast_cycle_req_n && io_ready && !io16;
               if (io_ready && (r.elapsed >= cycle_len(r.word, fast)))
               begin
                  // data sampled on the edge that negates the command
                  next_r.rsp_valid = !r.word[`REQ_WRITE];
                  next_r.rsp_data  = periph_data_in;
                  next_r.st        = xbus_pkg::BUS_IDLE;
                  next_r.mem_read_cmd_n           = 1'b1;
                  next_r.mem_write_cmd_n          = 1'b1;
                  next_r.io_read_cmd_n            = 1'b1;
                  next_r.io_write_cmd_n           = 1'b1;
                  next_r.microcontroller_select_n = 1'b1;
                  next_r.prog_select0_n           = 1'b1;
                  next_r.prog_select1_n           = 1'b1;
                  next_r.data_oe_n                = 1'b1;
                  next_r.dma_count_done           = 1'b0;
               end else if (r.elapsed != 3'h7) begin
                  // saturates so long ready stretches cannot wrap
                  next_r.elapsed = r.elapsed + 3'h1;
               end
            end
         end
         default: begin
            next_r.st = xbus_pkg::BUS_IDLE;
         end
      endcase

      if (suspend) begin
         next_r.microcontroller_select_n = 1'b1;
      end
   end

   // reset values; address not otherwise touched
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r                          <= '0;
         r.st                       <= xbus_pkg::BUS_IDLE;
         r.mem_read_cmd_n           <= 1'b1;
         r.mem_write_cmd_n          <= 1'b1;
         r.io_read_cmd_n            <= 1'b1;
         r.io_write_cmd_n           <= 1'b1;
         r.microcontroller_select_n <= 1'b1;
         r.prog_select0_n           <= 1'b1;
         r.prog_select1_n           <= 1'b1;
         r.data_oe_n                <= 1'b1;
         r.peripheral_reset_out     <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign periph_addr              = r.periph_addr;
   assign periph_data_out          = r.data_out;
   assign periph_data_oe_n         = r.data_oe_n;
   assign mem_read_cmd_n           = r.mem_read_cmd_n;
   assign mem_write_cmd_n          = r.mem_write_cmd_n;
   assign io_read_cmd_n            = r.io_read_cmd_n;
   assign io_write_cmd_n           = r.io_write_cmd_n;
   assign microcontroller_select_n = r.microcontroller_select_n;
   assign prog_select0_n           = r.prog_select0_n;
   assign prog_select1_n           = r.prog_select1_n;
   assign peripheral_reset_out     = r.peripheral_reset_out;
   assign dma_count_done           = r.dma_count_done;
   assign rsp_valid                = r.rsp_valid;
   assign rsp_data                 = r.rsp_data;
endmodule // periph_bus_master

// ===== src/periph_clock_div.sv
// bus clock generator: core clock divided by four, held low in suspend
`timescale 1ns/1ps
module periph_clock_div (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic suspend,
   output logic      bus_clock,
   output logic      bus_tick
);
   xbus_pkg::div_state_type r;
   xbus_pkg::div_state_type next_r;

   // counter phase 2 and 3 give the high half; tick marks each rising edge
   always_comb begin
      next_r     = r;
      next_r.cnt = r.cnt + 2'h1;
      if (suspend) begin
         next_r = '0;
      end
      next_r.clk_out = next_r.cnt[1];
      next_r.tick    = !suspend && (r.cnt == 2'h1);
   end

   // held at phase 0 through reset, so the bus clock stays low
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign bus_clock = r.clk_out;
   assign bus_tick  = r.tick;
endmodule // periph_clock_div

// ===== src/req_fifo.sv
// request buffer with valid and ready on both sides
`timescale 1ns/1ps
module req_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   count;
   } fifo_state_type;

   fifo_state_type   r;
   fifo_state_type   next_r;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // full and empty come straight from the occupancy count
   assign in_ready  = (r.count != (AW+1)'(DEPTH));
   assign out_valid = (r.count != '0);
   assign out_data  = mem[r.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // pointer wrap assumes a power-of-two depth
   always_comb begin
      next_r = r;
      if (push) begin
         next_r.wr = r.wr + 1'b1;
      end
      if (pop) begin
         next_r.rd = r.rd + 1'b1;
      end
      next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // storage carries no reset, only the pointers and the count do
   always_ff @(posedge clk) begin
      if (push) begin
         mem[r.wr] <= in_data;
      end
   end
endmodule // req_fifo

// ===== src/xbus_params.svh
// constants for the peripheral bus master: decodes, cycle lengths, timing
`ifndef XBUS_PARAMS_SVH
`define XBUS_PARAMS_SVH

// fixed microcontroller ports
`define MC_PORT_A        16'h0062
`define MC_PORT_B        16'h0066
// address driven during a dma i/o cycle
`define DMA_IO_ADDR      19'h0_0000
// cycle lengths in bus clocks, address clock included
`define LEN_8BIT         3'h6
`define LEN_16BIT        3'h3
`define FAST_LEN_16BIT   3'h2
`define FAST_LEN_8BIT    3'h3
// hard reset pulse: least time and clock period, both in ns
`define HARD_RESET_NS    1000000
`define CLK_PERIOD_NS    40
`define HARD_RESET_CYC   ((`HARD_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CNT_W        20
// request word layout
`define REQ_W            32
`define REQ_DMA          31
`define REQ_LAST         30
`define REQ_IO           29
`define REQ_WRITE        28
`define REQ_WIDE         27
`define REQ_ADDR_HI      26
`define REQ_ADDR_LO      8
`define REQ_DATA_HI      7
`define FIFO_DEPTH       8

`endif

// ===== src/xbus_pkg.sv
// types shared by the peripheral bus master modules
package xbus_pkg;

   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_ADDR,
      BUS_CMD
   } bus_state_type;

   typedef struct packed {
      bus_state_type st;
      logic [2:0]    elapsed;
      logic [31:0]   word;
      logic          mem_read_cmd_n;
      logic          mem_write_cmd_n;
      logic          io_read_cmd_n;
      logic          io_write_cmd_n;
      logic          microcontroller_select_n;
      logic          prog_select0_n;
      logic          prog_select1_n;
      logic [18:0]   periph_addr;
      logic [7:0]    data_out;
      logic          data_oe_n;
      logic          dma_count_done;
      logic          peripheral_reset_out;
      logic [19:0]   rst_cnt;
      logic          rsp_valid;
      logic [7:0]    rsp_data;
   } master_state_type;

   typedef struct packed {
      logic [1:0] cnt;
      logic       clk_out;
      logic       tick;
   } div_state_type;

endpackage

// ===== tb/bus_master_sva.sv
// assertion checker watching the peripheral bus master ports
`timescale 1ns/1ps
`include "xbus_params.svh"
module bus_master_sva (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        suspend,
   input wire logic        power_good_in,
   input wire logic [15:0] range0_base,
   input wire logic [15:0] range0_limit,
   input wire logic        periph_bus_clock,
   input wire logic [18:0] periph_addr,
   input wire logic        periph_data_oe_n,
   input wire logic        mem_read_cmd_n,
   input wire logic        mem_write_cmd_n,
   input wire logic        io_read_cmd_n,
   input wire logic        io_write_cmd_n,
   input wire logic        microcontroller_select_n,
   input wire logic        prog_select0_n,
   input wire logic        peripheral_reset_out,
   input wire logic        dma_count_done
);
   // command group and idle flag
   wire [3:0] cmd = {mem_read_cmd_n, mem_write_cmd_n,
                     io_read_cmd_n, io_write_cmd_n};
   wire       idle = &cmd;
   wire       io_on = !io_read_cmd_n || !io_write_cmd_n;

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // reset levels must show even while reset is held, so no disable here
   property p_rst;
      disable iff (1'b0) !resetn |=> idle && periph_data_oe_n &&
         peripheral_reset_out && !dma_count_done && microcontroller_select_n;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset levels wrong");

   // suspend stops the divider, so the phase check pauses with it
   property p_div;
      disable iff (!resetn || suspend) $rose(periph_bus_clock) |=>
         periph_bus_clock ##1 !periph_bus_clock [*2] ##1 periph_bus_clock;
   endproperty
   a_div: assert property (p_div)
      else $error("bus clock not divide by four");

   property p_susp;
      $past(suspend) && $past(resetn) |-> !periph_bus_clock &&
         !peripheral_reset_out && $stable(periph_addr);
   endproperty
   a_susp: assert property (p_susp)
      else $error("suspend levels wrong");

   property p_pg;
      $past(resetn) && !$past(power_good_in) && !$past(suspend)
         |-> peripheral_reset_out;
   endproperty
   a_pg: assert property (p_pg)
      else $error("peripheral reset free without power good");

   property p_one;
      $onehot0(~cmd);
   endproperty
   a_one: assert property (p_one)
      else $error("two commands at once");

   property p_mc;
      !microcontroller_select_n |-> io_on &&
         (periph_addr[15:0] == `MC_PORT_A || periph_addr[15:0] == `MC_PORT_B);
   endproperty
   a_mc: assert property (p_mc)
      else $error("controller select off its ports");

   property p_pcs;
      !prog_select0_n |-> io_on && periph_addr[15:0] >= range0_base &&
         periph_addr[15:0] <= range0_limit;
   endproperty
   a_pcs: assert property (p_pcs)
      else $error("select outside its range");

   property p_ioaddr;
      io_on |-> periph_addr[18:16] == 3'h0;
   endproperty
   a_ioaddr: assert property (p_ioaddr)
      else $error("upper address set on io");

   property p_cnt_done;
      $rose(dma_count_done) |-> !idle && $past(idle);
   endproperty
   a_cnt_done: assert property (p_cnt_done)
      else $error("count done off the command start");

   property p_rdoe;
      !(mem_read_cmd_n && io_read_cmd_n) |-> periph_data_oe_n;
   endproperty
   a_rdoe: assert property (p_rdoe)
      else $error("data driven during a read");

   property p_wroe;
      !(mem_write_cmd_n && io_write_cmd_n) |-> !periph_data_oe_n;
   endproperty
   a_wroe: assert property (p_wroe)
      else $error("data not driven during a write");

   c_mc: cover property ($fell(microcontroller_select_n));
   c_cnt_done: cover property ($rose(dma_count_done));
   c_pcs: cover property (!prog_select0_n);
endmodule // bus_master_sva

bind periph_bus_master bus_master_sva i_sva (.*);

// ===== tb/legacy_peripheral_bus_master_test.sv
// self-checking bench for the peripheral bus master
`timescale 1ns/1ps
`include "xbus_params.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module legacy_peripheral_bus_master_test;
   localparam int HR = 20;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        suspend = 1'b0;
   logic        power_good_in = 1'b1;
   logic        hard_reset_req = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_dma, req_last, req_io, req_write, req_wide;
   logic [18:0] req_addr = 19'h0_0000;
   logic [7:0]  req_wdata = 8'h00;
   logic        fast_en = 1'b0;
   logic [4:0]  wait_clks = 5'h00;
   logic        req_ready, rsp_valid, fast_cycle_req_n, io_ready;
   logic        periph_bus_clock, periph_data_oe_n, dma_count_done;
   logic        mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n;
   logic        microcontroller_select_n, prog_select0_n, prog_select1_n;
   logic        peripheral_reset_out, done_seen;
   logic [7:0]  rsp_data, periph_data_in, periph_data_out, last_wdata;
   logic [18:0] periph_addr, ad;
   logic [2:0]  sel;
   int          fail_count = 0;
   int          n_compared = 0;
   wire  [3:0]  cmd = {mem_read_cmd_n, mem_write_cmd_n,
                       io_read_cmd_n, io_write_cmd_n};

   // small hard reset count keeps the run short
   periph_bus_master #(.HARD_RESET_CYCLES(HR)) i_dut (.*,
      .range0_base(16'h0300), .range0_limit(16'h0307),
      .range1_base(16'h0400), .range1_limit(16'h040f));
   xbus_slave_model i_slave (.*, .rd_n(mem_read_cmd_n & io_read_cmd_n),
      .wr_n(mem_write_cmd_n & io_write_cmd_n));

   always #20 clk = ~clk;

   // every task step ends just after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic send(input logic [4:0] f, input logic [18:0] a,
                       input logic [7:0] d);
      {req_dma, req_last, req_io, req_write, req_wide} = f;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      while (req_ready !== 1'b1) tick(1);
      // valid stays up so back to back sends never glitch it; caller drops it
      tick(1);
   endtask

   // one request; dur is clocks with a command low, flags seen meanwhile
   task automatic run(input logic [4:0] f, input logic [18:0] a,
                      input logic [7:0] d, output int dur);
      send(f, a, d);
      req_valid = 1'b0;
      sel = 3'h0;
      done_seen = 1'b0;
      dur = 0;
      while (&cmd) tick(1);
      ad = periph_addr;
      while (!(&cmd)) begin
         sel |= ~{microcontroller_select_n, prog_select1_n, prog_select0_n};
         done_seen |= dma_count_done;
         dur++;
         tick(1);
      end
   endtask

   task automatic t_reset;
      tick(8);
      `CHK(peripheral_reset_out, 1'b1)
      `CHK(periph_data_oe_n, 1'b1)
      `CHK({io_read_cmd_n, io_write_cmd_n}, 2'h3)
      `CHK(dma_count_done, 1'b0)
      resetn = 1'b1;
      tick(2);
      `CHK(peripheral_reset_out, 1'b0)
   endtask

   task automatic t_mc;
      int d;
      logic [15:0] p [3] = '{16'h0062, 16'h0066, 16'h0064};
      for (int i = 0; i < 3; i++) begin
         run(5'h06, {3'h7, p[i]}, 8'h30 + i[7:0], d);
         `CHK(sel[2], i < 2)
         `CHK(ad, {3'h0, p[i]})
         `CHK(last_wdata, 8'h30 + i[7:0])
         `CHK(d, (`LEN_8BIT - 1) * 4)
      end
   endtask

   task automatic t_mem;
      int d;
      run(5'h00, 19'h5_a5c3, 8'h00, d);
      `CHK(ad, 19'h5_a5c3)
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_data, 8'h3c)
      run(5'h03, 19'h7_fffe, 8'h9a, d);
      `CHK(last_wdata, 8'h9a)
      `CHK(d, (`LEN_16BIT - 1) * 4)
   endtask

   task automatic t_pcs;
      int d;
      logic [15:0] a [4] = '{16'h0300, 16'h0307, 16'h0308, 16'h040f};
      logic [1:0]  e [4] = '{2'h1, 2'h1, 2'h0, 2'h2};
      for (int i = 0; i < 4; i++) begin
         run(5'h04, {3'h0, a[i]}, 8'h00, d);
         `CHK(sel[1:0], e[i])
         `CHK(rsp_data, ~a[i][7:0])
      end
   endtask

   // fast and slow slave answers
   task automatic t_fast;
      int d;
      fast_en = 1'b1;
      run(5'h02, 19'h1_0010, 8'h11, d);
      `CHK(d, (`FAST_LEN_8BIT - 1) * 4)
      run(5'h05, 19'h0_0080, 8'h00, d);
      `CHK(d, (`LEN_16BIT - 1) * 4)
      run(5'h01, 19'h2_0000, 8'h00, d);
      `CHK(d <= 4, 1'b1)
      wait_clks = 5'h12;
      run(5'h04, 19'h0_0066, 8'h00, d);
      `CHK(d, 20)
      wait_clks = 5'h00;
      fast_en = 1'b0;
   endtask

   task automatic t_dma;
      int d;
      run(5'h16, 19'h0_0062, 8'h44, d);
      `CHK(ad, `DMA_IO_ADDR)
      `CHK(done_seen, 1'b0)
      run(5'h1e, 19'h0_0062, 8'h45, d);
      `CHK(done_seen, 1'b1)
      `CHK(sel, 3'h0)
   endtask

   task automatic t_hard;
      int n = 0;
      power_good_in = 1'b0;
      tick(2);
      `CHK(peripheral_reset_out, 1'b1)
      power_good_in = 1'b1;
      tick(2);
      hard_reset_req = 1'b1;
      tick(1);
      hard_reset_req = 1'b0;
      while (peripheral_reset_out === 1'b1 && n < 200) begin
         n++;
         tick(1);
      end
      `CHK(n >= HR && n < HR + 4, 1'b1)
   endtask

   // buffer fills in suspend, refuses, then drains in order
   task automatic t_fifo;
      suspend = 1'b1;
      tick(2);
      for (int i = 0; i < `FIFO_DEPTH; i++) begin
         send(5'h06, 19'h0_0200 + i[18:0], i[7:0]);
      end
      req_valid = 1'b0;
      `CHK(req_ready, 1'b0)
      `CHK(periph_bus_clock, 1'b0)
      `CHK(peripheral_reset_out, 1'b0)
      suspend = 1'b0;
      for (int i = 0; i < `FIFO_DEPTH; i++) begin
         while (&cmd) tick(1);
         while (!(&cmd)) tick(1);
      end
      `CHK(last_wdata, 8'h07)
      `CHK(periph_addr, 19'h0_0207)
      `CHK(req_ready, 1'b1)
   endtask

   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      {req_dma, req_last, req_io, req_write, req_wide} = 5'h00;
      t_reset;
      t_mc;
      t_mem;
      t_pcs;
      t_fast;
      t_dma;
      t_hard;
      t_fifo;
      results;
   end

   // watchdog: the sequence needs a few thousand clocks at most
   initial begin
      #400000;
      fail_count++;
      results;
   end
endmodule // legacy_peripheral_bus_master_test

// ===== tb/xbus_slave_model.sv
// far side slave model: answers reads, asks for fast cycles, waits
`timescale 1ns/1ps
module xbus_slave_model (
   input  wire logic        clk,
   input  wire logic [18:0] periph_addr,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [7:0]  periph_data_out,
   input  wire logic        fast_en,
   input  wire logic [4:0]  wait_clks,
   output logic      [7:0]  periph_data_in,
   output logic             fast_cycle_req_n,
   output logic             io_ready,
   output logic      [7:0]  last_wdata
);
   logic [4:0] n = 5'h00;
   logic       rd_q = 1'b0;
   initial begin
      periph_data_in = 8'h00;
      fast_cycle_req_n = 1'b1;
      io_ready = 1'b1;
      last_wdata = 8'h00;
   end
   // reacts just after each edge, once the commands have settled
   always @(posedge clk) begin
      #1;
      // fast only after a command is decoded
      fast_cycle_req_n <= !(fast_en && (!rd_n || !wr_n));
      n <= (rd_n && wr_n) ? 5'h00 : (n == 5'h1f ? n : n + 5'h01);
      io_ready <= (rd_n && wr_n) || n >= wait_clks;
      // data held one clock past the read; released bus toggles
      if (!rd_n || rd_q) begin
         periph_data_in <= ~periph_addr[7:0];
      end else begin
         periph_data_in <= ~periph_data_in;
      end
      rd_q <= !rd_n;
      if (!wr_n) begin
         last_wdata <= periph_data_out;
      end
   end
endmodule // xbus_slave_model
